// File: pkg/rms_defines.svh
// Constants for the reset mode sequencer
`ifndef RMS_DEFINES_SVH
`define RMS_DEFINES_SVH
`define RMS_CLK_PERIOD_NS 25
`define RMS_LOCK_MAX_NS 10000
`define RMS_LOCK_CYC ((`RMS_LOCK_MAX_NS) / (`RMS_CLK_PERIOD_NS))
`define RMS_LOCK_DLY_CYC 24
`define RMS_PLL_SETTLE_CYC 200
`define RMS_CNT_W 9
`define RMS_STRAP_W 16
`define RMS_CNT_ZERO 9'h000
`define RMS_STRAP_ZERO 16'h0000
`define RMS_STAT_SOFT_BIT 4
`define RMS_STAT_W 8
`define RMS_STAT_ZERO 8'h00
`endif

// File: pkg/rms_pkg.sv
// Types for the reset mode sequencer
`default_nettype none
package rms_pkg;
    typedef enum logic [1:0] {
        RMS_ST_RESET = 2'b00,
        RMS_ST_WAIT = 2'b01,
        RMS_ST_SETTLE = 2'b11,
        RMS_ST_RUN = 2'b10
    } rms_state_t;
    typedef enum logic [1:0] {
        RMS_KIND_COLD = 2'b00,
        RMS_KIND_WARM = 2'b01,
        RMS_KIND_SOFT = 2'b11
    } rms_kind_t;
endpackage
`default_nettype wire

// File: logic/rms_sync.sv
// Two-flop synchroniser for a reset pin
`timescale 1ns/10ps
`default_nettype none
module rms_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pin and synchronised level
    input wire logic pin_n,
    output logic pin_sync_n
);
    logic stage1;

    // First flop feeds only the second
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            pin_sync_n <= 1'b0;
        end else begin
            stage1 <= pin_n;
            pin_sync_n <= stage1;
        end
    end
endmodule // rms_sync
`default_nettype wire

// File: logic/rms_sequencer.sv
// Reset mode sequencer: cold, warm and soft reset with clock-locked output
// Function
// - Three reset kinds: cold, hardware warm, watchdog soft.
// - Cold reset clears everything but the captured straps, clock synthesizer included.
// - Clock-locked rises within 10 us of system reset rising; boot waits.
// - System reset alone gives warm reset, clock synthesizer kept.
// - Watchdog timeout gives soft reset, same as warm, no pins.
// - Status bit 4 set on soft reset, cleared on warm or cold.
// - Clock-locked drops at once on any reset; low 26 clocks after soft.
// - Straps captured as a result of system reset rising.
`timescale 1ns/10ps
`default_nettype none
`include "rms_defines.svh"
module rms_sequencer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Board reset pins
    input wire logic pwron_rst_in_n,
    input wire logic sys_rst_in_n,
    // Watchdog timeout pulse, same clock
    input wire logic wdog_timeout,
    // Configuration straps
    input wire logic [`RMS_STRAP_W-1:0] expansion_address_straps,
    // Sequencer outputs
    output logic clk_locked,
    output logic core_rst_n,
    output logic synth_rst_n,
    output logic [`RMS_STRAP_W-1:0] strap_value,
    output logic [`RMS_STAT_W-1:0] timer_status,
    output rms_pkg::rms_kind_t last_kind
);
    ////////////////////////////////////////////////////////////////////
    logic pwron_sync_n;
    logic sys_sync_n;
    logic sys_prev_n;
    rms_pkg::rms_state_t state;
    rms_pkg::rms_state_t next_state;
    logic [`RMS_CNT_W-1:0] cnt;
    logic [`RMS_CNT_W-1:0] next_cnt;
    logic strap_done;
    logic soft_pending;
    logic [`RMS_STRAP_W-1:0] strap_meta;
    logic [`RMS_STRAP_W-1:0] strap_sync;

    // Pins are asynchronous to mclk; sync both
    rms_sync u_sync_pwron (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_n(pwron_rst_in_n),
        .pin_sync_n(pwron_sync_n)
    );
    rms_sync u_sync_sys (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_n(sys_rst_in_n),
        .pin_sync_n(sys_sync_n)
    );

    ////////////////////////////////////////////////////////////////////
    // Event decode; board keeps system reset low under power-on
    wire cold_req = !pwron_sync_n;
    wire warm_req = pwron_sync_n && !sys_sync_n;
    wire soft_req = wdog_timeout && (state == rms_pkg::RMS_ST_RUN);
    wire any_req = cold_req || !sys_sync_n || soft_req;
    wire sys_rise = sys_sync_n && !sys_prev_n;
    wire cnt_zero = (cnt == `RMS_CNT_ZERO);
    wire [`RMS_CNT_W-1:0] cnt_dec = cnt - 9'h001;
    // Settle delay: full synthesizer lock after cold, short after warm or soft
    wire [`RMS_CNT_W-1:0] settle_len = (last_kind == rms_pkg::RMS_KIND_COLD)
        ? `RMS_CNT_W'(`RMS_PLL_SETTLE_CYC) : `RMS_CNT_W'(`RMS_LOCK_DLY_CYC);

    // Next state
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            rms_pkg::RMS_ST_RESET: begin
                if (!any_req && soft_pending) begin
                    next_state = rms_pkg::RMS_ST_SETTLE; // No pins for soft
                    next_cnt = settle_len;
                end else if (sys_rise && pwron_sync_n) begin
                    next_state = rms_pkg::RMS_ST_WAIT;
                end
            end
            rms_pkg::RMS_ST_WAIT: begin
                next_state = rms_pkg::RMS_ST_SETTLE;
                next_cnt = settle_len;
            end
            rms_pkg::RMS_ST_SETTLE: begin
                if (cnt_zero && strap_done) begin
                    next_state = rms_pkg::RMS_ST_RUN;
                end else if (!cnt_zero) begin
                    next_cnt = cnt_dec;
                end
            end
            default: begin
                next_state = rms_pkg::RMS_ST_RUN;
            end
        endcase
        // Any reset drops everything at once
        if (any_req) begin
            next_state = rms_pkg::RMS_ST_RESET;
            next_cnt = `RMS_CNT_ZERO;
        end
    end

    // State and counter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= rms_pkg::RMS_ST_RESET;
            cnt <= `RMS_CNT_ZERO;
            sys_prev_n <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sys_prev_n <= sys_sync_n;
        end
    end

    // Straps are pins too; two flops, safe as a word since they sit still long before capture
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strap_meta <= `RMS_STRAP_ZERO;
            strap_sync <= `RMS_STRAP_ZERO;
        end else begin
            strap_meta <= expansion_address_straps;
            strap_sync <= strap_meta;
        end
    end

    // Strap capture on system reset rising, held till the next system reset rising
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strap_value <= `RMS_STRAP_ZERO;
            strap_done <= 1'b0;
        end else if (!sys_sync_n) begin
            strap_done <= 1'b0;
        end else if (sys_rise) begin
            strap_value <= strap_sync;
            strap_done <= 1'b1;
        end
    end

    // Reset kind and soft-reset status bit
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            last_kind <= rms_pkg::RMS_KIND_COLD;
            timer_status <= `RMS_STAT_ZERO;
            soft_pending <= 1'b0;
        end else if (cold_req) begin
            last_kind <= rms_pkg::RMS_KIND_COLD;
            timer_status[`RMS_STAT_SOFT_BIT] <= 1'b0;
            soft_pending <= 1'b0;
        end else if (warm_req) begin
            // A warm before a cold boot reaches run still counts synthesizer lock time
            if (last_kind != rms_pkg::RMS_KIND_COLD || state == rms_pkg::RMS_ST_RUN) begin
                last_kind <= rms_pkg::RMS_KIND_WARM;
            end
            timer_status[`RMS_STAT_SOFT_BIT] <= 1'b0;
            soft_pending <= 1'b0;
        end else if (soft_req) begin
            last_kind <= rms_pkg::RMS_KIND_SOFT;
            timer_status[`RMS_STAT_SOFT_BIT] <= 1'b1;
            soft_pending <= 1'b1;
        end else if (state == rms_pkg::RMS_ST_RESET) begin
            soft_pending <= 1'b0;
        end
    end

    // Outputs from flops; synthesizer reset only on cold
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clk_locked <= 1'b0;
            core_rst_n <= 1'b0;
            synth_rst_n <= 1'b0;
        end else begin
            clk_locked <= (next_state == rms_pkg::RMS_ST_RUN);
            core_rst_n <= (next_state == rms_pkg::RMS_ST_RUN);
            synth_rst_n <= !cold_req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    // Lock window after the eight quiet cycles of the antecedent
    localparam int LOCK_WIN_CYC = `RMS_LOCK_CYC - 8;
    sequence s_soft_evt;
        soft_req ##1 !clk_locked;
    endsequence
    sequence s_soft_hold;
        !clk_locked [*8];
    endsequence

    a_lock_drops_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        !sys_sync_n |=> !clk_locked)
        else $error("clock locked high during system reset");
    a_soft_lock_low: assert property (@(posedge mclk) disable iff (!rst_n)
        s_soft_evt |-> s_soft_hold)
        else $error("clock locked rose too soon after soft reset");
    a_lock_within_max: assert property (@(posedge mclk) disable iff (!rst_n)
        (sys_rise && pwron_sync_n) ##1 (sys_sync_n && pwron_sync_n && !wdog_timeout) [*8]
        |-> ##[0:LOCK_WIN_CYC] clk_locked)
        else $error("clock locked late after system reset release");
    a_soft_status_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (soft_req && pwron_sync_n && sys_sync_n) |=> timer_status[`RMS_STAT_SOFT_BIT])
        else $error("soft status bit not set");
    a_warm_status_clr: assert property (@(posedge mclk) disable iff (!rst_n)
        (!sys_sync_n) |=> !timer_status[`RMS_STAT_SOFT_BIT])
        else $error("soft status bit not cleared by pin reset");
    a_synth_kept_warm: assert property (@(posedge mclk) disable iff (!rst_n)
        (pwron_sync_n && $past(pwron_sync_n)) |=> synth_rst_n)
        else $error("synthesizer reset on warm reset");
    a_synth_cold: assert property (@(posedge mclk) disable iff (!rst_n)
        cold_req |=> !synth_rst_n && !core_rst_n)
        else $error("cold reset did not reset synthesizer");
    a_strap_capture: assert property (@(posedge mclk) disable iff (!rst_n)
        (sys_rise && pwron_sync_n) |=> strap_value == $past(strap_sync))
        else $error("straps not captured on system reset rise");
    a_release_gated: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(core_rst_n) |-> strap_done && clk_locked)
        else $error("internal reset released before capture");
endmodule // rms_sequencer
`default_nettype wire

// File: tb/rms_board.sv
// Board reset supervisor model driving the reset pins and straps
`timescale 1ns/10ps
`default_nettype none
`include "rms_defines.svh"
module rms_board (
    // Clock and observed lock
    input wire logic mclk,
    input wire logic clk_locked,
    // Reset pins and straps
    output logic pwron_rst_in_n,
    output logic sys_rst_in_n,
    output logic [`RMS_STRAP_W-1:0] expansion_address_straps
);
    // Both pins low from power up
    initial begin
        pwron_rst_in_n = 1'b0;
        sys_rst_in_n = 1'b0;
        expansion_address_straps = 16'h0000;
    end
    // Straps let go at the lock edge; inverted so a late sample shows up
    always @(posedge clk_locked) begin
        expansion_address_straps <= ~expansion_address_straps;
    end
    task automatic release_sys(input logic [`RMS_STRAP_W-1:0] cfg);
        expansion_address_straps <= cfg;
        repeat (2) @(posedge mclk); // 50 ns setup
        sys_rst_in_n <= 1'b1;
    endtask
    task automatic cold(input logic [`RMS_STRAP_W-1:0] cfg);
        @(posedge mclk); // Pins only move on a rising edge
        pwron_rst_in_n <= 1'b0;
        sys_rst_in_n <= 1'b0;
        repeat (80) @(posedge mclk); // 2000 ns both low
        pwron_rst_in_n <= 1'b1;
        @(posedge mclk); // System reset held one more cycle
        release_sys(cfg);
    endtask
    task automatic warm(input logic [`RMS_STRAP_W-1:0] cfg);
        @(posedge mclk); // Pins only move on a rising edge
        sys_rst_in_n <= 1'b0; // Power-on pin stays high
        repeat (20) @(posedge mclk); // 500 ns low
        release_sys(cfg);
    endtask
endmodule // rms_board
`default_nettype wire

// File: tb/tb_top.sv
// Testbench for the reset mode sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic mclk, rst_n, wdog_timeout, clk_locked, core_rst_n, synth_rst_n, synth_dropped;
    logic pwron_rst_in_n, sys_rst_in_n;
    logic [15:0] straps, strap_value;
    logic [7:0] timer_status;
    rms_pkg::rms_kind_t last_kind;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    rms_board rms_board_inst (.mclk(mclk), .clk_locked(clk_locked),
        .pwron_rst_in_n(pwron_rst_in_n), .sys_rst_in_n(sys_rst_in_n),
        .expansion_address_straps(straps));
    rms_sequencer rms_sequencer_inst (.mclk(mclk), .rst_n(rst_n),
        .pwron_rst_in_n(pwron_rst_in_n), .sys_rst_in_n(sys_rst_in_n),
        .wdog_timeout(wdog_timeout), .expansion_address_straps(straps),
        .clk_locked(clk_locked), .core_rst_n(core_rst_n), .synth_rst_n(synth_rst_n),
        .strap_value(strap_value), .timer_status(timer_status), .last_kind(last_kind));
    ////////////////////////////////////////////////////////////////////////
    // Clock, and a sticky flag for any synthesizer reset
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(negedge mclk) begin
        if (synth_rst_n !== 1'b1) synth_dropped = 1'b1;
    end
    // Hang guard, far above the several hundred cycles needed
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask
    // Counts cycles to lock, sampling away from the driving edge
    task automatic wait_lock(input int lim);
        n = 0;
        while (clk_locked !== 1'b1 && n < lim) begin
            @(negedge mclk);
            n++;
        end
    endtask
    task automatic pulse_wdog();
        @(posedge mclk);
        wdog_timeout <= 1'b1;
        @(posedge mclk);
        wdog_timeout <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic cold_boot(input logic [15:0] cfg);
        synth_dropped = 1'b0;
        rms_board_inst.cold(cfg);
        @(negedge mclk);
        chk({15'h0, synth_dropped}, 16'h0001, "synth not reset");
        chk({15'h0, core_rst_n}, 16'h0000, "core early");
        wait_lock(400);
        chk({15'h0, clk_locked}, 16'h0001, "lock late");
        chk({15'h0, core_rst_n}, 16'h0001, "core held");
        chk(strap_value, cfg, "straps");
        chk({8'h00, timer_status}, 16'h0000, "status cold");
        chk({14'h0, last_kind}, {14'h0, rms_pkg::RMS_KIND_COLD}, "kind cold");
    endtask
    task automatic soft_reset();
        synth_dropped = 1'b0;
        pulse_wdog();
        @(negedge mclk);
        chk({15'h0, clk_locked}, 16'h0000, "lock kept");
        wait_lock(60);
        chk({15'h0, (n >= 20 && n <= 40)}, 16'h0001, "soft delay");
        chk({8'h00, timer_status}, 16'h0010, "status soft");
        chk({14'h0, last_kind}, {14'h0, rms_pkg::RMS_KIND_SOFT}, "kind soft");
        chk({15'h0, synth_dropped}, 16'h0000, "synth soft");
    endtask
    // Warm reset with a watchdog pulse that must be ignored meanwhile
    task automatic warm_reset(input logic [15:0] cfg);
        synth_dropped = 1'b0;
        fork
            rms_board_inst.warm(cfg);
            begin
                repeat (10) @(posedge mclk);
                pulse_wdog();
            end
        join
        @(negedge mclk);
        chk({15'h0, clk_locked}, 16'h0000, "warm lock");
        chk({8'h00, timer_status}, 16'h0000, "status warm");
        wait_lock(400);
        chk({15'h0, clk_locked}, 16'h0001, "warm late");
        chk(strap_value, cfg, "warm straps");
        chk({14'h0, last_kind}, {14'h0, rms_pkg::RMS_KIND_WARM}, "kind warm");
        chk({15'h0, synth_dropped}, 16'h0000, "synth warm");
    endtask
    task automatic finish_test();
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        wdog_timeout = 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        cold_boot(16'ha55a);
        soft_reset();
        warm_reset(16'h3cc3);
        soft_reset();
        cold_boot(16'h0ff0);
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
